/* File: pkg/ais_pkg.sv */
// ais_pkg: constants and types shared by the converter sequencer and its link logic
// assumes a 100 MHz reference clock and a separate link sampling clock
package ais_pkg;

  // timing, in microseconds, and derived cycle counts
  localparam int CLK_MHZ       = 100;
  localparam int T_POR_US      = 500;
  localparam int T_CONV60_US   = 16600;
  localparam int T_CONV30_US   = 33200;
  localparam int POR_CYCLES    = T_POR_US * CLK_MHZ;
  localparam int CONV60_CYCLES = T_CONV60_US * CLK_MHZ;
  localparam int CONV30_CYCLES = T_CONV30_US * CLK_MHZ;
  localparam int CNT_W         = 22;

  // slave addressing and framing
  localparam logic [6:0] SLAVE_ADDR   = 7'h14;
  localparam logic       DIR_READ     = 1'b1;
  localparam int         CFG_RATE_POS = 0;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] ACK_DRIVE    = 4'h8;
  localparam logic [3:0] ACK_SLOT     = 4'h9;

  // rate select and reset values
  localparam logic        RATE_SLOW  = 1'b1;
  localparam logic        RATE_RST   = 1'b0;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] RESULT_MAX = 16'hffff;
  localparam int          RAW_W      = 18;

  typedef enum logic [1:0] {OP_CONV, OP_SLEEP, OP_IO} ais_op_t;

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_WR_DATA, LK_WR_ACK, LK_RD_DATA, LK_RD_ACK, LK_HOLD
  } ais_link_t;

endpackage

/* File: rtl/ais_sync2.sv */
// ais_sync2: two flop level synchroniser
// assumes d_i is a level that stays put for several destination clocks
`timescale 1ns/1ps
module ais_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule

/* File: rtl/ais_conv_core.sv */
// ais_conv_core: conversion timer with slow rate offset correction and clamped result
// assumes start_i is a one cycle pulse on clk_i and samples are on clk_i too
`timescale 1ns/1ps
module ais_conv_core
  import ais_pkg::*;
#(
  parameter int CONV60_CYC = CONV60_CYCLES,
  parameter int CONV30_CYC = CONV30_CYCLES
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    start_i,
  input  wire logic                    slow_i,
  input  wire logic signed [RAW_W-1:0] raw_i,
  input  wire logic signed [RAW_W-1:0] offset_i,
  output logic                         busy_o,
  output logic [15:0]                  result_o
);
  logic [CNT_W-1:0]       cnt_q, cnt_d;
  logic                   busy_q, busy_d;
  logic                   slow_q, slow_d;
  logic [15:0]            res_q, res_d;
  logic signed [RAW_W:0]  corr;

  function automatic logic [15:0] clamp(input logic signed [RAW_W:0] v);
    if (v < 0)
      clamp = RESULT_RST;
    else if (v > $signed({3'b000, RESULT_MAX}))
      clamp = RESULT_MAX;
    else
      clamp = v[15:0];
  endfunction

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    slow_d = slow_q;
    res_d  = res_q;
    // slow rate subtracts the calibrated offset inside the same cycle
    corr   = slow_q ? (RAW_W+1)'(raw_i - offset_i) : (RAW_W+1)'(raw_i);
    if (!busy_q && start_i) begin
      busy_d = 1'b1;
      slow_d = slow_i;
      cnt_d  = slow_i ? CNT_W'(CONV30_CYC - 1) : CNT_W'(CONV60_CYC - 1);
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        res_d  = clamp(corr);
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      slow_q <= RATE_RST;
      res_q  <= RESULT_RST;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      slow_q <= slow_d;
      res_q  <= res_d;
    end
  end

  assign busy_o   = busy_q;
  assign result_o = res_q;
endmodule

/* File: rtl/ais_seq_top.sv */
// ais_seq_top: two wire slave and conversion sequencer of a 16 bit converter
// assumes an outside master drives scl and a pull-up resolves sda from sda_oe_o
`timescale 1ns/1ps
module ais_seq_top #(
  parameter int POR_CYC    = ais_pkg::POR_CYCLES,
  parameter int CONV60_CYC = ais_pkg::CONV60_CYCLES,
  parameter int CONV30_CYC = ais_pkg::CONV30_CYCLES
) (
  input  wire logic                             ref_clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             link_clk_i,
  input  wire logic                             scl_i,
  input  wire logic                             sda_i,
  output logic                                  sda_o,
  output logic                                  sda_oe_o,
  input  wire logic signed [ais_pkg::RAW_W-1:0] raw_sample_i,
  input  wire logic signed [ais_pkg::RAW_W-1:0] offset_sample_i,
  output ais_pkg::ais_op_t                      op_state_o,
  output logic                                  slow_rate_select_o,
  output logic [15:0]                           result_o
);
  import ais_pkg::*;

  // reference domain state
  logic [CNT_W-1:0] por_cnt_q, por_cnt_d;
  logic             por_q, por_d;
  logic             kick_q, kick_d;
  logic             busy_q, busy_d;
  logic             tog_prev_q, tog_prev_d;
  logic             rate_eff_q, rate_eff_d;
  ais_op_t          op_q, op_d;
  logic [15:0]      core_res;
  logic             core_busy, tog_s, rate_s, io_s, tog_edge;

  // link domain state
  ais_link_t        st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d;
  logic [15:0]      rd_q, rd_d;
  logic             rw_q, rw_d;
  logic             oe_q, oe_d;
  logic             hi_q, hi_d;
  logic             valid_q, valid_d;
  logic             rate_q, rate_d;
  logic             tog_q, tog_d;
  logic             pend_q, pend_d;
  logic             io_q, io_d;
  logic             scl_p_q, scl_p_d;
  logic             sda_p_q, sda_p_d;
  logic             sda_lo_q, sda_lo_d;
  logic             lrst, scl_s, sda_s, busy_s, rise_e, fall_e, start_e, stop_e, busy_eff;
  logic [7:0]       sh_in;

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
    shift_in = {v[6:0], b};
  endfunction

  // reference domain: power-on hold, conversion start, state report
  ais_sync2 u_sync_tog (
    .clk_i (ref_clk_i),
    .rst_i (reset_i),
    .d_i   (tog_q),
    .q_o   (tog_s)
  );
  ais_sync2 u_sync_rate (
    .clk_i (ref_clk_i),
    .rst_i (reset_i),
    .d_i   (rate_q),
    .q_o   (rate_s)
  );
  ais_sync2 u_sync_io (
    .clk_i (ref_clk_i),
    .rst_i (reset_i),
    .d_i   (io_q),
    .q_o   (io_s)
  );

  ais_conv_core #(
    .CONV60_CYC (CONV60_CYC),
    .CONV30_CYC (CONV30_CYC)
  ) u_core (
    .clk_i    (ref_clk_i),
    .rst_i    (reset_i),
    .start_i  (kick_q),
    .slow_i   (rate_eff_q),
    .raw_i    (raw_sample_i),
    .offset_i (offset_sample_i),
    .busy_o   (core_busy),
    .result_o (core_res)
  );

  assign tog_edge = tog_s ^ tog_prev_q;

  always_comb begin
    por_cnt_d  = por_cnt_q;
    por_d      = por_q;
    kick_d     = 1'b0;
    tog_prev_d = tog_s;
    rate_eff_d = rate_eff_q;
    if (por_q) begin
      if (por_cnt_q == CNT_W'(POR_CYC - 1)) begin
        por_d  = 1'b0;
        kick_d = 1'b1;
      end else begin
        por_cnt_d = por_cnt_q + CNT_W'(1);
      end
    end else if (tog_edge && !core_busy && !kick_q) begin
      kick_d     = 1'b1;
      rate_eff_d = rate_s;
    end
    // conversion runs from the power-on hold or the kick until the core drops busy
    busy_d = por_q | kick_q | kick_d | core_busy;
    if (busy_d)
      op_d = OP_CONV;
    else if (io_s)
      op_d = OP_IO;
    else
      op_d = OP_SLEEP;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      por_cnt_q  <= '0;
      por_q      <= 1'b1;
      kick_q     <= 1'b0;
      busy_q     <= 1'b1;
      tog_prev_q <= 1'b0;
      rate_eff_q <= RATE_RST;
      op_q       <= OP_CONV;
    end else begin
      por_cnt_q  <= por_cnt_d;
      por_q      <= por_d;
      kick_q     <= kick_d;
      busy_q     <= busy_d;
      tog_prev_q <= tog_prev_d;
      rate_eff_q <= rate_eff_d;
      op_q       <= op_d;
    end
  end

  assign op_state_o         = op_q;
  assign slow_rate_select_o = rate_eff_q;
  assign result_o           = core_res;

  // link domain: oversampled bus pins, slave protocol
  ais_sync2 u_sync_rst (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (por_q),
    .q_o   (lrst)
  );
  // scl is only ever sampled, never driven
  ais_sync2 u_sync_scl (
    .clk_i (link_clk_i),
    .rst_i (lrst),
    .d_i   (scl_i),
    .q_o   (scl_s)
  );
  ais_sync2 u_sync_sda (
    .clk_i (link_clk_i),
    .rst_i (lrst),
    .d_i   (sda_i),
    .q_o   (sda_s)
  );
  ais_sync2 u_sync_busy (
    .clk_i (link_clk_i),
    .rst_i (lrst),
    .d_i   (busy_q),
    .q_o   (busy_s)
  );

  assign rise_e   = scl_s & ~scl_p_q;
  assign fall_e   = ~scl_s & scl_p_q;
  assign start_e  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_e   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign busy_eff = busy_s | pend_q;
  assign sh_in    = shift_in(sh_q, sda_s);

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    rd_d     = rd_q;
    rw_d     = rw_q;
    oe_d     = oe_q;
    hi_d     = hi_q;
    valid_d  = valid_q;
    rate_d   = rate_q;
    tog_d    = tog_q;
    pend_d   = pend_q;
    scl_p_d  = scl_s;
    sda_p_d  = sda_s;
    sda_lo_d = 1'b0;
    if (busy_s)
      pend_d = 1'b0;
    if (start_e) begin
      st_d  = LK_ADDR;
      cnt_d = '0;
      oe_d  = 1'b0;
    end else if (stop_e) begin
      st_d    = LK_IDLE;
      oe_d    = 1'b0;
      valid_d = 1'b0;
      if (valid_q) begin
        tog_d  = ~tog_q;
        pend_d = 1'b1;
      end
    end else begin
      unique case (st_q)
        LK_IDLE, LK_HOLD: begin
          oe_d = 1'b0;
        end
        LK_ADDR: begin
          if (rise_e) begin
            sh_d  = sh_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == BIT_LAST) begin
              if (sh_in[7:1] == SLAVE_ADDR && !busy_eff) begin
                st_d = LK_ADDR_ACK;
                rw_d = sh_in[0];
              end else begin
                st_d = LK_HOLD;
              end
            end
          end
        end
        LK_ADDR_ACK: begin
          if (fall_e && cnt_q == ACK_DRIVE) begin
            oe_d = 1'b1;
          end else if (rise_e) begin
            cnt_d = ACK_SLOT;
          end else if (fall_e && cnt_q == ACK_SLOT) begin
            valid_d = 1'b1;
            cnt_d   = '0;
            if (rw_q == DIR_READ) begin
              st_d = LK_RD_DATA;
              rd_d = core_res;
              hi_d = 1'b1;
              oe_d = ~core_res[15];
            end else begin
              st_d = LK_WR_DATA;
              oe_d = 1'b0;
            end
          end
        end
        LK_WR_DATA: begin
          if (rise_e) begin
            sh_d  = sh_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == BIT_LAST) begin
              rate_d = sh_in[CFG_RATE_POS];
              st_d   = LK_WR_ACK;
            end
          end
        end
        LK_WR_ACK: begin
          if (fall_e && cnt_q == ACK_DRIVE) begin
            oe_d = 1'b1;
          end else if (rise_e) begin
            cnt_d = ACK_SLOT;
          end else if (fall_e && cnt_q == ACK_SLOT) begin
            oe_d = 1'b0;
            st_d = LK_HOLD;
          end
        end
        LK_RD_DATA: begin
          if (rise_e) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall_e) begin
            if (cnt_q == ACK_DRIVE) begin
              oe_d = 1'b0;
              if (hi_q) begin
                st_d = LK_RD_ACK;
              end else begin
                st_d    = LK_HOLD;
                valid_d = 1'b0;
                tog_d   = ~tog_q;
                pend_d  = 1'b1;
              end
            end else begin
              rd_d = {rd_q[14:0], 1'b0};
              oe_d = ~rd_q[14];
            end
          end
        end
        LK_RD_ACK: begin
          // master ack or nak on the high byte is not checked
          if (rise_e) begin
            cnt_d = ACK_SLOT;
          end else if (fall_e && cnt_q == ACK_SLOT) begin
            rd_d  = {rd_q[14:0], 1'b0};
            oe_d  = ~rd_q[14];
            hi_d  = 1'b0;
            cnt_d = '0;
            st_d  = LK_RD_DATA;
          end
        end
      endcase
    end
    io_d = valid_d | (st_d == LK_ADDR_ACK);
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      st_q     <= LK_IDLE;
      cnt_q    <= '0;
      sh_q     <= '0;
      rd_q     <= RESULT_RST;
      rw_q     <= 1'b0;
      oe_q     <= 1'b0;
      hi_q     <= 1'b0;
      valid_q  <= 1'b0;
      rate_q   <= RATE_RST;
      tog_q    <= 1'b0;
      pend_q   <= 1'b0;
      io_q     <= 1'b0;
      scl_p_q  <= 1'b0;
      sda_p_q  <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      rd_q     <= rd_d;
      rw_q     <= rw_d;
      oe_q     <= oe_d;
      hi_q     <= hi_d;
      valid_q  <= valid_d;
      rate_q   <= rate_d;
      tog_q    <= tog_d;
      pend_q   <= pend_d;
      io_q     <= io_d;
      scl_p_q  <= scl_p_d;
      sda_p_q  <= sda_p_d;
      sda_lo_q <= sda_lo_d;
    end
  end

  assign sda_o    = sda_lo_q;
  assign sda_oe_o = oe_q;
endmodule

/* File: tb/ais_seq_top_asserts.sv */
// ais_seq_top_asserts: sequencer and bus properties of ais_seq_top
// assumes raw and offset samples stay still near each conversion end
`timescale 1ns/1ps
module ais_seq_top_asserts
  import ais_pkg::*;
#(
  parameter int POR_CYC    = 100,
  parameter int CONV60_CYC = 4000,
  parameter int CONV30_CYC = 8000
) (
  input wire logic                             ref_clk_i,
  input wire logic                             reset_i,
  input wire logic                             link_clk_i,
  input wire logic                             scl_i,
  input wire logic                             sda_i,
  input wire logic                             sda_o,
  input wire logic                             sda_oe_o,
  input wire logic signed [ais_pkg::RAW_W-1:0] raw_sample_i,
  input wire logic signed [ais_pkg::RAW_W-1:0] offset_sample_i,
  input ais_pkg::ais_op_t                      op_state_o,
  input wire logic                             slow_rate_select_o,
  input wire logic [15:0]                      result_o
);
  int          conv_d, conv_q, up_d, up_q, diff, len;
  logic [15:0] exp_res;
  // cycles spent converting, cycles since reset, expected result
  always_comb begin
    conv_d = (op_state_o == OP_CONV) ? conv_q + 1 : 0;
    up_d = (up_q < 100000) ? up_q + 1 : up_q;
    len = slow_rate_select_o ? CONV30_CYC : CONV60_CYC;
    diff = slow_rate_select_o ? int'(raw_sample_i) - int'(offset_sample_i) : int'(raw_sample_i);
    exp_res = (diff < 0) ? 16'h0000 : (diff > 65535) ? 16'hffff : diff[15:0];
  end
  always_ff @(posedge ref_clk_i) begin
    conv_q <= reset_i ? 0 : conv_d;
    up_q <= reset_i ? 0 : up_d;
  end
  sequence s_conv_done;
    op_state_o == OP_CONV ##1 op_state_o == OP_SLEEP;
  endsequence
  property p_order;
    @(posedge ref_clk_i) disable iff (reset_i) op_state_o != $past(op_state_o) |-> op_state_o ==
      (($past(op_state_o) == OP_CONV) ? OP_SLEEP : ($past(op_state_o) == OP_SLEEP) ? OP_IO : OP_CONV);
  endproperty
  a_order: assert property (p_order) else $error("state order broken");
  property p_por;
    @(posedge ref_clk_i) disable iff (reset_i) $fell(reset_i) |-> result_o == 16'h0000 && !slow_rate_select_o;
  endproperty
  a_por: assert property (p_por) else $error("reset values wrong");
  property p_por_hold;
    @(posedge ref_clk_i) disable iff (reset_i) up_q < POR_CYC + CONV60_CYC - 8 |-> op_state_o == OP_CONV;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("first conversion too short");
  property p_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      $changed(result_o) |-> op_state_o == OP_CONV || $past(op_state_o) == OP_CONV;
  endproperty
  a_hold: assert property (p_hold) else $error("result moved outside conversion");
  property p_rate;
    @(posedge ref_clk_i) disable iff (reset_i) s_conv_done |-> conv_q >= len - 8 && conv_q <= len + POR_CYC + 16;
  endproperty
  a_rate: assert property (p_rate) else $error("conversion length wrong");
  property p_result;
    @(posedge ref_clk_i) disable iff (reset_i) s_conv_done |-> result_o == exp_res;
  endproperty
  a_result: assert property (p_result) else $error("result value wrong");
  property p_nak;
    @(posedge link_clk_i) disable iff (reset_i || up_q < POR_CYC) $rose(sda_oe_o) |-> op_state_o != OP_CONV;
  endproperty
  a_nak: assert property (p_nak) else $error("sda pulled while converting");
  property p_pull;
    @(posedge link_clk_i) disable iff (reset_i || up_q < POR_CYC)
      sda_oe_o |-> sda_o == 1'b0 && op_state_o == OP_IO;
  endproperty
  a_pull: assert property (p_pull) else $error("sda driven high");
  property p_edge;
    @(posedge link_clk_i) disable iff (reset_i || up_q < POR_CYC) $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  a_edge: assert property (p_edge) else $error("sda moved outside scl low");
endmodule

bind ais_seq_top ais_seq_top_asserts #(.POR_CYC(POR_CYC), .CONV60_CYC(CONV60_CYC), .CONV30_CYC(CONV30_CYC))
  u_asserts (.ref_clk_i, .reset_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .raw_sample_i,
  .offset_sample_i, .op_state_o, .slow_rate_select_o, .result_o);

/* File: tb/ais_i2c_master.sv */
// ais_i2c_master: behavioural two wire master, clock idles high between frames
// assumes a pull-up wire whose level comes back on sda_i
`timescale 1ns/1ps
module ais_i2c_master #(
  parameter int T_NS = 400
) (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // one clock: data set mid low, sampled late in high
  task automatic bit_x(input logic v, output logic s);
    #(2*T_NS) sda_low_o = !v;
    #(2*T_NS) scl_o = 1'b1;
    #(2*T_NS) s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_v, output logic [7:0] rx, output logic ack_s);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ack_v, ack_s);
  endtask
  task automatic start();
    #(2*T_NS) sda_low_o = 1'b0;
    #(2*T_NS) scl_o = 1'b1;
    #(2*T_NS) sda_low_o = 1'b1;
    #(2*T_NS) scl_o = 1'b0;
  endtask
  task automatic stop();
    #(2*T_NS) sda_low_o = 1'b1;
    #(2*T_NS) scl_o = 1'b1;
    #(2*T_NS) sda_low_o = 1'b0;
    #(4*T_NS);
  endtask
endmodule

/* File: tb/ais_seq_top_test.sv */
// ais_seq_top_test: bus transfers and conversion sequencing of ais_seq_top
// assumes the master model and the bound checker are compiled with it
`timescale 1ns/1ps
module ais_seq_top_test;
  import ais_pkg::*;
  localparam int POR_T = 100;
  localparam int C60_T = 4000;
  localparam int C30_T = 8000;
  logic                    ref_clk, reset, link_clk, scl, m_low, sda_o, sda_oe, slow, ack;
  logic signed [RAW_W-1:0] raw, offs;
  logic [15:0]             res, d;
  ais_op_t                 op;
  int                      fails, num_checks;
  wire                     sda_w = !(m_low || (sda_oe && !sda_o));
  ais_i2c_master m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_w));
  ais_seq_top #(.POR_CYC(POR_T), .CONV60_CYC(C60_T), .CONV30_CYC(C30_T)) dut (
    .ref_clk_i(ref_clk), .reset_i(reset), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .raw_sample_i(raw), .offset_sample_i(offs),
    .op_state_o(op), .slow_rate_select_o(slow), .result_o(res));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic note(input string s);
    $display("test done: %s", s);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task automatic set_in(input logic signed [RAW_W-1:0] r, input logic signed [RAW_W-1:0] o);
    @(posedge ref_clk);
    raw <= r;
    offs <= o;
  endtask
  task automatic wait_sleep();
    int n = 0;
    while (op !== OP_SLEEP && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      close_out();
    end
  endtask
  task automatic rd(input logic [6:0] a, output logic ak, output logic [15:0] v);
    logic [7:0] hi, lo;
    logic       x;
    m.start();
    m.xfer({a, 1'b1}, 1'b1, hi, ak);
    lo = 8'h00;
    if (ak === 1'b0) begin
      m.xfer(8'hff, 1'b0, hi, x);
      m.xfer(8'hff, 1'b1, lo, x);
    end
    v = {hi, lo};
  endtask
  task automatic wr(input logic [7:0] cfg, output logic ak);
    logic [7:0] x8;
    logic       a1, a2;
    m.start();
    m.xfer({7'h14, 1'b0}, 1'b1, x8, a1);
    m.xfer(cfg, 1'b1, x8, a2);
    ak = a1 | a2;
  endtask
  initial begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    raw = 18'sh0_1234;
    offs = 18'sh0_0100;
    do_reset();
    wait_sleep();
    check(slow, 1'b0);
    check(res, 16'h1234);
    note("power up");
    rd(7'h15, ack, d);
    m.stop();
    check(ack, 1'b1);
    check(op, OP_SLEEP);
    note("foreign address");
    rd(7'h14, ack, d);
    check(ack, 1'b0);
    check(d, 16'h1234);
    repeat (100) @(posedge ref_clk);
    check(op, OP_CONV);
    set_in(18'sh1_ffff, 18'sh0_0100);
    rd(7'h14, ack, d);
    m.stop();
    check(ack, 1'b1);
    note("read then busy");
    wait_sleep();
    set_in(18'sh0_0100, 18'sh0_0010);
    wr(8'h01, ack);
    check(ack, 1'b0);
    rd(7'h14, ack, d);
    m.stop();
    check(ack, 1'b0);
    check(d, 16'hffff);
    wait_sleep();
    check(slow, 1'b1);
    check(res, 16'h00f0);
    note("write repeated start read");
    set_in(-18'sd3, 18'sh0_0010);
    wr(8'h00, ack);
    m.stop();
    repeat (100) @(posedge ref_clk);
    check(op, OP_CONV);
    wait_sleep();
    check(slow, 1'b0);
    set_in(18'sh0_0100, 18'sh0_0010);
    rd(7'h14, ack, d);
    m.stop();
    check(d, 16'h0000);
    wait_sleep();
    check(res, 16'h0100);
    note("write stop and clamp");
    do_reset();
    @(posedge ref_clk);
    #1;
    check(res, 16'h0000);
    check(slow, 1'b0);
    note("second reset");
    close_out();
  end
endmodule
